//--- core/bie_regs.svh
`ifndef BIE_REGS_SVH
`define BIE_REGS_SVH
// Operation
// - bit_set_skip 0111bbbfffff: tested bit one discards fetched word, two cycles, no flags
// - call 1001kkkkkkkk pushes incremented program counter as return address
// - call loads pc 7:0 from literal, 10:9 from status 6:5, bit 8 zero
// - clear_file 0000011fffff zeroes the file register and sets zero_flag
// - watchdog_clear 000000000100 clears watchdog, prescaler if assigned, sets both flags
// - complement_file 001001dfffff inverts file into w or file, updates zero_flag
// - decrement_file 000011dfffff decrements file into w or file, updates zero_flag
// - decrement_skip_zero 001011dfffff decrements, no flags, zero result skips next
// - move_working_to_file 0000001fffff copies w into file, no flags
// - load_option 000000000010 copies w into option register, no flags
// - return_literal 1000kkkkkkkk loads w with literal, pc from stack_top, two cycles
// - xor_literal 1111kkkkkkkk xors w with literal into w, updates zero_flag
// - xor_file 000110dfffff xors w with file into w or file, updates zero_flag
// - option register is six bits, write-only, every reset sets all ones; the bus still reads it back at offset 0xC

// =========================================================
// register offsets (byte addresses)
`define BIE_OFS_CTRL 4'h0
`define BIE_OFS_STAT 4'h4
`define BIE_OFS_WREG 4'h8
`define BIE_OFS_PCOP 4'hC

// =========================================================
// fields and reset values
`define BIE_CTRL_RUN 0
`define BIE_ST_ZERO 2
`define BIE_ST_PD_N 3
`define BIE_ST_TO_N 4
`define BIE_ST_PA_HI 6
`define BIE_ST_PA_LO 5
`define BIE_OPT_PSA 3
`define BIE_STAT_RST 8'h18
`define BIE_OPT_RST 6'h3F
`define BIE_PC_RST 11'h7FF
`define BIE_RUN_RST 1'b1

// =========================================================
// instruction encodings
`define BIE_ENC_NOP 12'h000
`define BIE_ENC_OPTION 12'h002
`define BIE_ENC_WDCLR 12'h004
`define BIE_ENC_CLEAR_WORKING 12'h040
`define BIE_ENC_MOVE_WORKING_TO_FILE 7'h01
`define BIE_ENC_CLEAR_FILE 7'h03
`define BIE_ENC_DECREMENT_FILE 6'h03
`define BIE_ENC_XOR_FILE 6'h06
`define BIE_ENC_COMPLEMENT_FILE 6'h09
`define BIE_ENC_DECSZ 6'h0B
`define BIE_ENC_BSKIP 4'h7
`define BIE_ENC_RETLIT 4'h8
`define BIE_ENC_CALL 4'h9
`define BIE_ENC_XORLIT 4'hF
`endif

//--- core/bie_pkg.sv
package bie_pkg;
  typedef enum logic {BIE_PH_READ, BIE_PH_EXEC} bie_ph_t;
  typedef enum logic [3:0] {
    BIE_OP_NOP, BIE_OP_OPTION, BIE_OP_WDCLR, BIE_OP_CLEAR_WORKING, BIE_OP_MOVE_WORKING_TO_FILE, BIE_OP_CLEAR_FILE,
    BIE_OP_DECREMENT_FILE, BIE_OP_XOR_FILE, BIE_OP_COMPLEMENT_FILE, BIE_OP_DECSZ, BIE_OP_BSKIP, BIE_OP_RETLIT,
    BIE_OP_CALL, BIE_OP_XORLIT
  } bie_op_t;
  typedef struct packed {
    logic hit;
    logic wr;
    logic [3:0] ofs;
  } bie_bus_t;
  typedef struct packed {
    logic wr_w;
    logic wr_f;
    logic upd_z;
    logic skip;
    logic push;
    logic pop;
  } bie_ctl_t;
endpackage

//--- core/bie_fmem.sv
`timescale 1ns/100ps
module bie_fmem #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);
  logic [DW-1:0] mem_ff [0:(1<<AW)-1];

  // contents are undefined after reset, as in the real file space
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
    rd_data <= mem_ff[rd_addr];
  end
endmodule

//--- core/bie_stack.sv
`timescale 1ns/100ps
module bie_stack #(
  parameter int DW = 11,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [DW-1:0] push_data,
  output logic [DW-1:0] top
);
  logic [DW-1:0] ent_ff [0:DEPTH-1];

  assign top = ent_ff[0];

  // push shifts down and loses the deepest entry; pop repeats the deepest
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk) begin
        if (rst) begin
          ent_ff[i] <= '0;
        end else if (push) begin
          ent_ff[i] <= (i == 0) ? push_data : ent_ff[(i == 0) ? 0 : i-1];
        end else if (pop) begin
          ent_ff[i] <= ent_ff[(i == DEPTH-1) ? i : i+1];
        end
      end
    end
  endgenerate
endmodule

//--- core/bie_core.sv
`timescale 1ns/100ps
`include "bie_regs.svh"
module bie_core
  import bie_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  output logic [10:0] PROG_ADDR,
  input wire logic [11:0] PROG_DATA,
  output logic [5:0] OPTION_OUT,
  output logic WDT_CLR,
  output logic PRESC_CLR,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  // =========================================================
  // state
  bie_ph_t ph_ff;
  logic [10:0] pc_ff;
  logic [11:0] ir_ff;
  logic flush_ff;
  logic [7:0] w_ff;
  logic [7:0] status_ff;
  logic [5:0] option_ff;
  logic run_ff;
  logic wdt_clr_ff;
  logic presc_clr_ff;
  logic [31:0] hrdata_ff;
  bie_bus_t bus_ff;

  // =========================================================
  // decode
  wire exec = (ph_ff == BIE_PH_EXEC);
  // a discarded word executes as the all-zero no-op
  wire [11:0] ir = flush_ff ? `BIE_ENC_NOP : ir_ff;
  wire [7:0] lit = ir[7:0];
  wire [2:0] bsel = ir[7:5];
  wire dest_f = ir[5];
  wire [4:0] faddr = ir[4:0];
  bie_op_t op;
  assign op = (ir == `BIE_ENC_OPTION) ? BIE_OP_OPTION :
              (ir == `BIE_ENC_WDCLR) ? BIE_OP_WDCLR :
              (ir == `BIE_ENC_CLEAR_WORKING) ? BIE_OP_CLEAR_WORKING :
              (ir[11:5] == `BIE_ENC_MOVE_WORKING_TO_FILE) ? BIE_OP_MOVE_WORKING_TO_FILE :
              (ir[11:5] == `BIE_ENC_CLEAR_FILE) ? BIE_OP_CLEAR_FILE :
              (ir[11:6] == `BIE_ENC_DECREMENT_FILE) ? BIE_OP_DECREMENT_FILE :
              (ir[11:6] == `BIE_ENC_XOR_FILE) ? BIE_OP_XOR_FILE :
              (ir[11:6] == `BIE_ENC_COMPLEMENT_FILE) ? BIE_OP_COMPLEMENT_FILE :
              (ir[11:6] == `BIE_ENC_DECSZ) ? BIE_OP_DECSZ :
              (ir[11:8] == `BIE_ENC_BSKIP) ? BIE_OP_BSKIP :
              (ir[11:8] == `BIE_ENC_RETLIT) ? BIE_OP_RETLIT :
              (ir[11:8] == `BIE_ENC_CALL) ? BIE_OP_CALL :
              (ir[11:8] == `BIE_ENC_XORLIT) ? BIE_OP_XORLIT : BIE_OP_NOP;

  // =========================================================
  // datapath
  logic [7:0] fdat;
  logic [10:0] stk_top;
  wire [7:0] fdec = fdat - 8'h01;
  wire file_op = (op == BIE_OP_COMPLEMENT_FILE) | (op == BIE_OP_DECREMENT_FILE) | (op == BIE_OP_DECSZ) |
                 (op == BIE_OP_XOR_FILE);
  wire [7:0] res = (op == BIE_OP_COMPLEMENT_FILE) ? ~fdat :
                   (op == BIE_OP_DECREMENT_FILE || op == BIE_OP_DECSZ) ? fdec :
                   (op == BIE_OP_XOR_FILE) ? (w_ff ^ fdat) :
                   (op == BIE_OP_XORLIT) ? (w_ff ^ lit) :
                   (op == BIE_OP_RETLIT) ? lit :
                   (op == BIE_OP_MOVE_WORKING_TO_FILE) ? w_ff : 8'h00;
  bie_ctl_t ctl;
  assign ctl.wr_w = exec & ((op == BIE_OP_CLEAR_WORKING) | (op == BIE_OP_XORLIT) |
                    (op == BIE_OP_RETLIT) | (file_op & ~dest_f));
  assign ctl.wr_f = exec & ((op == BIE_OP_MOVE_WORKING_TO_FILE) | (op == BIE_OP_CLEAR_FILE) | (file_op & dest_f));
  // decrement_skip_zero is the one file_op operation that leaves the zero flag alone
  assign ctl.upd_z = exec & ((op == BIE_OP_CLEAR_WORKING) | (op == BIE_OP_CLEAR_FILE) |
                     (op == BIE_OP_COMPLEMENT_FILE) | (op == BIE_OP_DECREMENT_FILE) |
                     (op == BIE_OP_XOR_FILE) | (op == BIE_OP_XORLIT));
  assign ctl.skip = exec & (((op == BIE_OP_BSKIP) & fdat[bsel]) |
                    ((op == BIE_OP_DECSZ) & (fdec == 8'h00)));
  assign ctl.push = exec & (op == BIE_OP_CALL);
  assign ctl.pop = exec & (op == BIE_OP_RETLIT);
  wire [10:0] call_pc = {status_ff[`BIE_ST_PA_HI:`BIE_ST_PA_LO], 1'b0, lit};
  wire [10:0] nxt_pc = ctl.push ? call_pc :
                       ctl.pop ? stk_top : 11'(pc_ff + 11'h001);
  // the word already fetched is thrown away on skip, call and return
  wire nxt_flush = ctl.skip | ctl.push | ctl.pop;
  wire wd_clr = exec & (op == BIE_OP_WDCLR);

  bie_fmem #(.DW(8), .AW(5)) u_fmem (
    .clk(CORE_CLK),
    .rd_addr(faddr),
    .rd_data(fdat),
    .wr_en(ctl.wr_f),
    .wr_addr(faddr),
    .wr_data(res)
  );

  // pc_ff already points past this word, so it is the return address
  bie_stack #(.DW(11), .DEPTH(2)) u_stack (
    .clk(CORE_CLK),
    .rst(RST),
    .push(ctl.push),
    .pop(ctl.pop),
    .push_data(pc_ff),
    .top(stk_top)
  );

  // =========================================================
  // bus slave
  wire bus_take = HSEL & HTRANS[1] & HREADY;
  wire bus_wr = bus_ff.hit & bus_ff.wr;
  wire in_map = (HADDR[31:4] == 28'h0000000);
  wire [31:0] rd_mux = !in_map ? 32'h0000_0000 :
                       (HADDR[3:0] == `BIE_OFS_CTRL) ? {31'h0, run_ff} :
                       (HADDR[3:0] == `BIE_OFS_STAT) ? {24'h0, status_ff} :
                       (HADDR[3:0] == `BIE_OFS_WREG) ? {24'h0, w_ff} :
                       (HADDR[3:0] == `BIE_OFS_PCOP) ? {5'h0, pc_ff, 10'h0, option_ff} :
                       32'h0000_0000;
  wire wr_ctrl = bus_wr & (bus_ff.ofs == `BIE_OFS_CTRL);
  wire wr_stat = bus_wr & (bus_ff.ofs == `BIE_OFS_STAT);
  // the two watchdog flags stay read-only from the bus
  wire [7:0] bus_status = {HWDATA[7:5], status_ff[`BIE_ST_TO_N:`BIE_ST_PD_N], HWDATA[2:0]};
  wire [7:0] base_status = wr_stat ? bus_status : status_ff;
  wire [7:0] z_status = ctl.upd_z ?
         {base_status[7:3], (res == 8'h00), base_status[1:0]} : base_status;
  wire [7:0] nxt_status = wd_clr ?
         {z_status[7:5], 2'b11, z_status[2:0]} : z_status;

  assign HRDATA = hrdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bus_ff <= '0;
      hrdata_ff <= 32'h0000_0000;
      run_ff <= `BIE_RUN_RST;
    end else begin
      bus_ff <= '{hit: bus_take & in_map, wr: HWRITE, ofs: HADDR[3:0]};
      if (bus_take && !HWRITE) begin
        hrdata_ff <= rd_mux;
      end
      if (wr_ctrl) begin
        run_ff <= HWDATA[`BIE_CTRL_RUN];
      end
    end
  end

  // =========================================================
  // sequencer: one read phase then one execute phase per instruction cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ph_ff <= BIE_PH_READ;
    end else begin
      case (ph_ff)
        BIE_PH_READ: ph_ff <= run_ff ? BIE_PH_EXEC : BIE_PH_READ;
        BIE_PH_EXEC: ph_ff <= BIE_PH_READ;
        default: ph_ff <= BIE_PH_READ;
      endcase
    end
  end

  // nothing fetched before reset, so the first cycle runs as a no-op
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pc_ff <= `BIE_PC_RST;
      ir_ff <= `BIE_ENC_NOP;
      flush_ff <= 1'b1;
    end else if (exec) begin
      pc_ff <= nxt_pc;
      ir_ff <= PROG_DATA;
      flush_ff <= nxt_flush;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      w_ff <= 8'h00;
      status_ff <= `BIE_STAT_RST;
      option_ff <= `BIE_OPT_RST;
    end else begin
      status_ff <= nxt_status;
      if (ctl.wr_w) begin
        w_ff <= res;
      end
      if (exec && op == BIE_OP_OPTION) begin
        option_ff <= w_ff[5:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wdt_clr_ff <= 1'b0;
      presc_clr_ff <= 1'b0;
    end else begin
      wdt_clr_ff <= wd_clr;
      presc_clr_ff <= wd_clr & option_ff[`BIE_OPT_PSA];
    end
  end

  assign PROG_ADDR = pc_ff;
  assign OPTION_OUT = option_ff;
  assign WDT_CLR = wdt_clr_ff;
  assign PRESC_CLR = presc_clr_ff;

  // =========================================================
  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  bskip_flush_a: assert property (exec && op == BIE_OP_BSKIP && fdat[bsel]
      |=> flush_ff && $stable(status_ff) ##2 flush_ff == 1'b0 || $past(ir_ff) != 12'h000)
    else $error("bit skip did not discard next word");
  call_push_a: assert property (exec && op == BIE_OP_CALL
      |=> stk_top == $past(pc_ff))
    else $error("call pushed wrong return address");
  call_target_a: assert property (exec && op == BIE_OP_CALL
      |=> pc_ff == {$past(status_ff[6:5]), 1'b0, $past(ir_ff[7:0])} && flush_ff)
    else $error("call loaded wrong program counter");
  clear_working_zero_a: assert property (exec && op == BIE_OP_CLEAR_WORKING
      |=> w_ff == 8'h00 && status_ff[`BIE_ST_ZERO])
    else $error("clear working failed");
  clear_file_write_a: assert property (exec && op == BIE_OP_CLEAR_FILE
      |-> ctl.wr_f && res == 8'h00 ##1 status_ff[`BIE_ST_ZERO])
    else $error("clear file failed");
  wdclr_flags_a: assert property (exec && op == BIE_OP_WDCLR
      |=> WDT_CLR && status_ff[4:3] == 2'b11 && PRESC_CLR == $past(option_ff[3]))
    else $error("watchdog clear failed");
  complement_file_route_a: assert property (exec && op == BIE_OP_COMPLEMENT_FILE && !dest_f
      |=> w_ff == ~$past(fdat) && status_ff[`BIE_ST_ZERO] == ($past(fdat) == 8'hFF))
    else $error("complement to working failed");
  decrement_file_route_a: assert property (exec && op == BIE_OP_DECREMENT_FILE
      |-> ctl.wr_f == dest_f && res == 8'(fdat - 8'h01))
    else $error("decrement routed wrongly");
  decsz_skip_a: assert property (exec && op == BIE_OP_DECSZ
      |=> flush_ff == ($past(fdat) == 8'h01) &&
          status_ff[2] == $past(status_ff[2]))
    else $error("decrement skip zero failed");
  move_working_to_file_data_a: assert property (exec && op == BIE_OP_MOVE_WORKING_TO_FILE
      |-> ctl.wr_f && res == w_ff && !ctl.upd_z)
    else $error("move to file failed");
  option_load_a: assert property (exec && op == BIE_OP_OPTION
      |=> OPTION_OUT == $past(w_ff[5:0]) && $stable(status_ff))
    else $error("option load failed");
  retlit_pc_a: assert property (exec && op == BIE_OP_RETLIT
      |=> w_ff == $past(ir_ff[7:0]) && pc_ff == $past(stk_top) && flush_ff)
    else $error("return literal failed");
  xorlit_res_a: assert property (exec && op == BIE_OP_XORLIT
      |=> w_ff == ($past(w_ff) ^ $past(ir_ff[7:0])))
    else $error("xor literal failed");
  xor_file_res_a: assert property (exec && op == BIE_OP_XOR_FILE && dest_f
      |-> ctl.wr_f && res == (w_ff ^ fdat) && !ctl.wr_w)
    else $error("xor file failed");
  option_rst_a: assert property ($fell(RST) |-> OPTION_OUT == 6'h3F)
    else $error("option not all ones after reset");
  nop_idle_a: assert property (exec && op == BIE_OP_NOP
      |=> $stable(w_ff) && pc_ff == 11'($past(pc_ff) + 11'h001))
    else $error("no-op changed state");
  seq_pc_a: assert property (exec && !ctl.push && !ctl.pop
      |=> pc_ff == 11'($past(pc_ff) + 11'h001) ##1 ph_ff == BIE_PH_EXEC || !$past(run_ff))
    else $error("program counter did not advance by one");
endmodule

//--- sim/bie_prog_mem.sv
`timescale 1ns/100ps
// =========================================================
// program memory seen from the core's fetch port
module bie_prog_mem (
  input wire logic [10:0] addr,
  output logic [11:0] data
);
  logic [11:0] mem [0:2047];

  // unloaded words read as no-op, so gaps between test segments stay harmless
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 12'h000;
    end
  end

  // combinational answer, allowed by the fetch timing of the core
  assign data = mem[addr];
endmodule

//--- sim/tb_baseline_instr_exec_subset.sv
`timescale 1ns/100ps
module tb_baseline_instr_exec_subset;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, wdt_clr, presc_clr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [10:0] prog_addr;
  logic [11:0] prog_data;
  logic [5:0] option_out;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int wdt_n = 0;
  int presc_n = 0;
  int j = 1;
  logic [10:0] trace [$];
  logic [10:0] last_addr = 11'h7FF;
  // {address, word}; segments sit apart so a halt lands on padding no-ops
  logic [23:0] prog [25] = '{24'h000FA5, 24'h00102A, 24'h00224A,
    24'h0101AA, 24'h01118A, 24'h01226A,
    24'h0200EA, 24'h0217EA, 24'h0221AA, 24'h0230CA,
    24'h030040, 24'h031F01, 24'h03202B, 24'h0332EB, 24'h0341AB, 24'h035040, 24'h0362CB,
    24'h04070B, 24'h041F3C,
    24'h050FCB, 24'h051002, 24'h052004, 24'h053F38, 24'h054002, 24'h055004};
  logic [23:0] prog_tail [3] = '{24'h05606C, 24'h06018C, 24'h061940};
  logic [10:0] wait_a [7] = '{11'h006, 11'h016, 11'h027, 11'h03A, 11'h045, 11'h05A, 11'h066};
  logic [7:0] exp_w [7] = '{8'h5A, 8'hA5, 8'hFE, 8'hFF, 8'hC3, 8'h30, 8'hA7};
  logic [7:0] exp_s [7] = '{8'h78, 8'h7C, 8'h78, 8'h7C, 8'h78, 8'h7C, 8'h78};

  bie_core bie_core_inst (.CORE_CLK(clk), .RST(rst), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .OPTION_OUT(option_out), .WDT_CLR(wdt_clr),
    .PRESC_CLR(presc_clr), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));

  bie_prog_mem bie_prog_mem_inst (.addr(prog_addr), .data(prog_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // =========================================================
  // reporting
  task results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // =========================================================
  // single-word bus transfer, zero-wait slave still waited for
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // =========================================================
  // monitors: fetch address trace, clear pulses, hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!rst && prog_addr !== last_addr) begin
      trace.push_back(prog_addr);
      last_addr <= prog_addr;
    end
    if (wdt_clr === 1'b1) wdt_n <= wdt_n + 1;
    if (presc_clr === 1'b1) presc_n <= presc_n + 1;
    if (cycles == 5000) begin
      $display("[ERR] run did not finish in time");
      fail_count++;
      results();
    end
  end

  // =========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge clk);
    foreach (prog[i]) bie_prog_mem_inst.mem[prog[i][23:12]] = prog[i][11:0];
    foreach (prog_tail[i]) bie_prog_mem_inst.mem[prog_tail[i][23:12]] = prog_tail[i][11:0];
    bie_prog_mem_inst.mem[11'h640] = 12'h8A7;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("option pins", {26'h0, option_out}, 32'h3F);
    ahb(1'b1, 32'h0, 32'h0, rd);
    // page bits 11 so the call lands in the upper page
    ahb(1'b1, 32'h4, 32'h60, rd);
    ahb(1'b0, 32'hC, 32'h0, rd);
    chk("option field", {26'h0, rd[5:0]}, 32'h3F);
    chk("bus response", {31'h0, hresp}, 32'h0);
    ahb(1'b1, 32'h0, 32'h1, rd);
    for (int i = 0; i < 7; i++) begin
      while (prog_addr !== wait_a[i]) @(posedge clk);
      ahb(1'b1, 32'h0, 32'h0, rd);
      ahb(1'b0, 32'h8, 32'h0, rd);
      chk("working reg", rd, {24'h0, exp_w[i]});
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk("status reg", rd, {24'h0, exp_s[i]});
      if (i == 5) chk("option pins", {26'h0, option_out}, 32'h30);
      ahb(1'b1, 32'h0, 32'h1, rd);
    end
    chk("watchdog clears", 32'(wdt_n), 32'h2);
    chk("prescaler clears", 32'(presc_n), 32'h1);
    for (int k = 0; k < 32; k++) begin
      chk("fetch order", {21'h0, trace[k]}, k);
    end
    foreach (trace[k]) if (trace[k] === 11'h640 && j == 1) j = k;
    chk("call from", {21'h0, trace[j-1]}, 32'h62);
    chk("call target next", {21'h0, trace[j+1]}, 32'h641);
    chk("return address", {21'h0, trace[j+2]}, 32'h62);
    results();
  end
endmodule
